// ### epr_regs.svh
// Constants for the exception priority resolver
`ifndef EPR_REGS_SVH
`define EPR_REGS_SVH

// ----------------------------------------
// Source counts
// ----------------------------------------
`define EPR_NSRC 58
`define EPR_IDX_W 6
`define EPR_IRQ_IDX 0

// ----------------------------------------
// Vector addresses
// ----------------------------------------
`define EPR_VEC_PAGE 8'hff
`define EPR_VEC_RESET 16'hfffe
`define EPR_VEC_CLKMON 16'hfffc
`define EPR_VEC_WATCHDOG 16'hfffa
`define EPR_VEC_TRAP 16'hfff8
`define EPR_VEC_SWI 16'hfff6
`define EPR_VEC_NMI 16'hfff4
`define EPR_MASK_TOP 8'hf2
`define EPR_MASK_LOW 8'h80

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EPR_PRIO_RST 8'hf2
`define EPR_IMASK_RST 1'b1
`define EPR_XMASK_RST 1'b1
`define EPR_EDGESEL_RST 1'b0

`endif

// ### epr_pkg.sv
// Types shared by the exception priority resolver
`include "epr_regs.svh"

package epr_pkg;

	typedef logic [`EPR_NSRC-1:0] epr_src_t;
	typedef logic [`EPR_IDX_W-1:0] epr_idx_t;

	typedef enum logic [3:0] {
		GR_NONE,
		GR_RESET,
		GR_CLKMON,
		GR_WATCHDOG,
		GR_ILLEGAL,
		GR_SWI,
		GR_NMI,
		GR_MASKABLE,
		GR_TRAP
	} epr_grant_e;

endpackage

// ### epr_irq_pin.sv
// Maskable request pin: level or falling-edge recognition
`timescale 1ns/1ns
`include "epr_regs.svh"

module epr_irq_pin (
	input logic sys_clk,
	input logic nrst,
	input logic irqPinN,
	input logic selWr,
	input logic selWrData,
	input logic specialMode,
	input logic latchClr,
	output logic edgeSel_r,
	output logic irqReq
);

	logic pinPrev_r, pinPrev_nxt;
	logic latch_r, latch_nxt;
	logic edgeSel_nxt;
	logic selWritten_r, selWritten_nxt;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		pinPrev_nxt = irqPinN;
		// Set wins so an edge in the clearing cycle is kept
		if (pinPrev_r && !irqPinN)
			latch_nxt = 1'b1;
		else if (latchClr)
			latch_nxt = 1'b0;
		else
			latch_nxt = latch_r;
		edgeSel_nxt = edgeSel_r;
		selWritten_nxt = selWritten_r;
		if (selWr && !selWritten_r)
		begin
			selWritten_nxt = 1'b1;
			// First write counts only outside special modes
			if (!specialMode)
				edgeSel_nxt = selWrData;
		end
		else if (selWr && specialMode)
			edgeSel_nxt = selWrData;
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pinPrev_r <= 1'b1;
			latch_r <= 1'b0;
			edgeSel_r <= `EPR_EDGESEL_RST;
			selWritten_r <= 1'b0;
		end
		else
		begin
			pinPrev_r <= pinPrev_nxt;
			latch_r <= latch_nxt;
			edgeSel_r <= edgeSel_nxt;
			selWritten_r <= selWritten_nxt;
		end
	end

	assign irqReq = edgeSel_r ? latch_r : !irqPinN;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	edge_capture_a: assert property (
		pinPrev_r && !irqPinN |=> latch_r)
		else $error("falling edge not latched");
	edge_clear_a: assert property (
		latchClr && !(pinPrev_r && !irqPinN) |=> !latch_r)
		else $error("edge latch not cleared on service");
	sel_once_a: assert property (
		selWr && selWritten_r && !specialMode |=> $stable(edgeSel_r))
		else $error("edge select rewritten in normal mode");
	level_mode_a: assert property (
		!edgeSel_r |-> irqReq == !irqPinN)
		else $error("level mode does not follow pin");

	special_rewrite_c: cover property (selWr && selWritten_r && specialMode);

endmodule

// ### epr_resolver.sv
// Exception priority resolver: reset, non-maskable and maskable requests
`timescale 1ns/1ns
`include "epr_regs.svh"

module epr_resolver (
	input logic sys_clk,
	input logic nrst,
	input logic resetPinReq,
	input logic clkMonReq,
	input logic watchdogReq,
	input logic illegalOpReq,
	input logic swiReq,
	input logic nmiPinN,
	input logic irqPinN,
	input logic [`EPR_NSRC-1:1] flagSet,
	input logic [`EPR_NSRC-1:1] flagClr,
	input epr_pkg::epr_src_t localEn,
	input logic iMaskWr,
	input logic iMaskWrData,
	input logic xMaskWr,
	input logic xMaskWrData,
	input logic prioWr,
	input logic [7:0] prioWrData,
	input logic edgeSelWr,
	input logic edgeSelWrData,
	input logic specialMode,
	input logic serviceStart,
	output logic iMask_r,
	output logic xMask_r,
	output logic [7:0] prio_r,
	output logic edgeSel_r,
	output logic [`EPR_NSRC-1:1] flags_r,
	output logic pendingAny_r,
	output logic vectorValid_r,
	output logic [15:0] vectorAddr_r,
	output epr_pkg::epr_grant_e grant_r
);

	logic iMask_nxt, xMask_nxt;
	logic [7:0] prio_nxt;
	logic [`EPR_NSRC-1:1] flags_nxt;
	logic pendingAny_nxt, vectorValid_nxt;
	logic [15:0] vectorAddr_nxt;
	epr_pkg::epr_grant_e grant_nxt;

	logic irqReq;
	logic latchClr;
	epr_pkg::epr_src_t reqs, active;
	logic nmiAct, maskAny, elevOk, elevHit;
	logic [7:0] elevDiff;
	epr_pkg::epr_idx_t elevIdx, winIdx, lowIdx;
	epr_pkg::epr_grant_e kind;

	// ----------------------------------------
	// Maskable pin
	// ----------------------------------------
	epr_irq_pin uPin (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.irqPinN(irqPinN),
		.selWr(edgeSelWr),
		.selWrData(edgeSelWrData),
		.specialMode(specialMode),
		.latchClr(latchClr),
		.edgeSel_r(edgeSel_r),
		.irqReq(irqReq)
	);

	// ----------------------------------------
	// Source flags
	// ----------------------------------------
	// Set wins over clear so no event is lost
	genvar g;
	generate
		for (g = 1; g < `EPR_NSRC; g++)
		begin : genFlag
			assign flags_nxt[g] = flagSet[g] | (flags_r[g] & !flagClr[g]);
		end
	endgenerate

	// ----------------------------------------
	// Priority resolution
	// ----------------------------------------
	always_comb
	begin
		reqs = {flags_r, irqReq};
		// Global mask gates every maskable source, elevated or not
		active = reqs & localEn & {`EPR_NSRC{!iMask_r}};
		maskAny = |active;
		nmiAct = !nmiPinN && !xMask_r;
		elevDiff = `EPR_MASK_TOP - prio_r;
		elevIdx = elevDiff[`EPR_IDX_W:1];
		elevOk = !prio_r[0] && prio_r >= `EPR_MASK_LOW && prio_r <= `EPR_MASK_TOP;
		elevHit = elevOk && active[elevIdx];
		lowIdx = '0;
		for (int i = `EPR_NSRC - 1; i >= 0; i--)
		begin
			if (active[i])
				lowIdx = `EPR_IDX_W'(i);
		end
		winIdx = elevHit ? elevIdx : lowIdx;
		if (resetPinReq)
			kind = epr_pkg::GR_RESET;
		else if (clkMonReq)
			kind = epr_pkg::GR_CLKMON;
		else if (watchdogReq)
			kind = epr_pkg::GR_WATCHDOG;
		else if (illegalOpReq)
			kind = epr_pkg::GR_ILLEGAL;
		else if (swiReq)
			kind = epr_pkg::GR_SWI;
		else if (nmiAct)
			kind = epr_pkg::GR_NMI;
		else if (maskAny)
			kind = epr_pkg::GR_MASKABLE;
		else
			kind = epr_pkg::GR_TRAP;
	end

	assign latchClr = serviceStart && kind == epr_pkg::GR_MASKABLE
		&& winIdx == `EPR_IRQ_IDX;

	// ----------------------------------------
	// Masks, elevation and grant
	// ----------------------------------------
	always_comb
	begin
		iMask_nxt = iMaskWr ? iMaskWrData : iMask_r;
		xMask_nxt = xMaskWr ? xMaskWrData : xMask_r;
		// Elevation is frozen while maskable interrupts are live
		prio_nxt = (prioWr && iMask_r) ? prioWrData : prio_r;
		pendingAny_nxt = kind != epr_pkg::GR_TRAP;
		vectorValid_nxt = serviceStart;
		vectorAddr_nxt = vectorAddr_r;
		grant_nxt = grant_r;
		if (serviceStart)
		begin
			grant_nxt = kind;
			case (kind)
				epr_pkg::GR_RESET: vectorAddr_nxt = `EPR_VEC_RESET;
				epr_pkg::GR_CLKMON: vectorAddr_nxt = `EPR_VEC_CLKMON;
				epr_pkg::GR_WATCHDOG: vectorAddr_nxt = `EPR_VEC_WATCHDOG;
				epr_pkg::GR_ILLEGAL: vectorAddr_nxt = `EPR_VEC_TRAP;
				epr_pkg::GR_SWI: vectorAddr_nxt = `EPR_VEC_SWI;
				epr_pkg::GR_NMI: vectorAddr_nxt = `EPR_VEC_NMI;
				// Slot address depends on index only, never on elevation
				epr_pkg::GR_MASKABLE: vectorAddr_nxt = {`EPR_VEC_PAGE,
					8'(`EPR_MASK_TOP - 8'({winIdx, 1'b0}))};
				epr_pkg::GR_TRAP: vectorAddr_nxt = `EPR_VEC_TRAP;
				default: vectorAddr_nxt = `EPR_VEC_TRAP;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			iMask_r <= `EPR_IMASK_RST;
			xMask_r <= `EPR_XMASK_RST;
			prio_r <= `EPR_PRIO_RST;
			flags_r <= '0;
			pendingAny_r <= 1'b0;
			vectorValid_r <= 1'b0;
			vectorAddr_r <= `EPR_VEC_RESET;
			grant_r <= epr_pkg::GR_NONE;
		end
		else
		begin
			iMask_r <= iMask_nxt;
			xMask_r <= xMask_nxt;
			prio_r <= prio_nxt;
			flags_r <= flags_nxt;
			pendingAny_r <= pendingAny_nxt;
			vectorValid_r <= vectorValid_nxt;
			vectorAddr_r <= vectorAddr_nxt;
			grant_r <= grant_nxt;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	vec_page_a: assert property (
		vectorValid_r |-> vectorAddr_r[15:8] == `EPR_VEC_PAGE
			&& vectorAddr_r[7:0] >= `EPR_MASK_LOW && !vectorAddr_r[0])
		else $error("vector outside top page");
	reset_first_a: assert property (
		serviceStart && resetPinReq |=> vectorValid_r && vectorAddr_r == `EPR_VEC_RESET)
		else $error("reset request did not win");
	nmi_order_a: assert property (
		serviceStart && !resetPinReq && !clkMonReq && !watchdogReq && !illegalOpReq
			&& swiReq |=> vectorAddr_r == `EPR_VEC_SWI)
		else $error("swi did not outrank nmi and maskable");
	mask_block_a: assert property (
		serviceStart && iMask_r && !resetPinReq && !clkMonReq && !watchdogReq
			&& !illegalOpReq && !swiReq && !nmiAct |=> vectorAddr_r == `EPR_VEC_TRAP)
		else $error("maskable source taken while masked");
	mask_write_a: assert property (
		iMaskWr |=> iMask_r == $past(iMaskWrData))
		else $error("global mask write lost");
	elev_first_a: assert property (
		serviceStart && kind == epr_pkg::GR_MASKABLE && elevHit
			|=> vectorAddr_r == {`EPR_VEC_PAGE, $past(prio_r)})
		else $error("elevated source not granted first");
	prio_lock_a: assert property (
		prioWr && !iMask_r |=> $stable(prio_r))
		else $error("elevation written while unmasked");
	trap_empty_a: assert property (
		serviceStart && kind == epr_pkg::GR_TRAP |=> vectorAddr_r == `EPR_VEC_TRAP
			&& grant_r == epr_pkg::GR_TRAP)
		else $error("empty service did not fetch trap");
	flag_hold_a: assert property (
		flags_r[2] && !flagClr[2] |=> flags_r[2])
		else $error("flag dropped without clear");
	slot_fixed_a: assert property (
		serviceStart && kind == epr_pkg::GR_MASKABLE |=> vectorAddr_r[7:0]
			== 8'(`EPR_MASK_TOP - 8'({$past(winIdx), 1'b0})))
		else $error("maskable vector moved");


	// ----------------------------------------
	// Grant output, mask, elevation, flag and pending checks
	// ----------------------------------------
	valid_pulse_a: assert property (
		vectorValid_r == $past(serviceStart))
		else $error("vector valid not one cycle after service");
	grant_hold_a: assert property (
		!serviceStart |=> $stable(vectorAddr_r) && $stable(grant_r))
		else $error("vector changed without service");
	valid_grant_a: assert property (
		vectorValid_r |-> grant_r != epr_pkg::GR_NONE)
		else $error("vector presented with no grant");
	nonmask_slot_a: assert property (
		vectorValid_r && grant_r != epr_pkg::GR_MASKABLE |-> vectorAddr_r >= `EPR_VEC_NMI)
		else $error("non-maskable vector below top six slots");
	maskable_slot_a: assert property (
		vectorValid_r && grant_r == epr_pkg::GR_MASKABLE |-> vectorAddr_r < `EPR_VEC_NMI)
		else $error("maskable vector inside top six slots");
	clkmon_win_a: assert property (
		serviceStart && !resetPinReq && clkMonReq |=> vectorAddr_r == `EPR_VEC_CLKMON)
		else $error("clock monitor reset did not win");
	watchdog_win_a: assert property (
		serviceStart && !resetPinReq && !clkMonReq && watchdogReq
			|=> vectorAddr_r == `EPR_VEC_WATCHDOG)
		else $error("watchdog reset did not win");
	illegal_win_a: assert property (
		serviceStart && !resetPinReq && !clkMonReq && !watchdogReq && illegalOpReq
			|=> grant_r == epr_pkg::GR_ILLEGAL && vectorAddr_r == `EPR_VEC_TRAP)
		else $error("opcode trap did not win");
	nmi_masked_a: assert property (
		serviceStart && xMask_r |=> grant_r != epr_pkg::GR_NMI)
		else $error("nmi pin taken while its mask set");
	nmi_level_a: assert property (
		serviceStart && !xMask_r && !nmiPinN && !resetPinReq && !clkMonReq && !watchdogReq
			&& !illegalOpReq && !swiReq |=> grant_r == epr_pkg::GR_NMI)
		else $error("nmi level request not granted");
	xmask_write_a: assert property (
		xMaskWr |=> xMask_r == $past(xMaskWrData))
		else $error("nmi mask write lost");
	prio_take_a: assert property (
		prioWr && iMask_r |=> prio_r == $past(prioWrData))
		else $error("elevation write lost while masked");
	elev_mask_a: assert property (
		serviceStart && iMask_r && elevOk |=> grant_r != epr_pkg::GR_MASKABLE)
		else $error("elevated source taken while masked");
	flag_set_a: assert property (
		flagSet[2] |=> flags_r[2])
		else $error("flag set lost");
	reset_pending_a: assert property (
		resetPinReq |=> pendingAny_r)
		else $error("reset request not seen as pending");
	pending_idle_a: assert property (
		!resetPinReq && !clkMonReq && !watchdogReq && !illegalOpReq && !swiReq && iMask_r
			&& (xMask_r || nmiPinN) |=> !pendingAny_r)
		else $error("pending shown with no live source");

	elev_grant_c: cover property (serviceStart && elevHit && elevIdx != lowIdx);
	trap_grant_c: cover property (serviceStart && kind == epr_pkg::GR_TRAP);
	nmi_grant_c: cover property (serviceStart && kind == epr_pkg::GR_NMI);
	irq_grant_c: cover property (latchClr && edgeSel_r);

endmodule

// ### epr_ext_logic.sv
// Far-side request logic driving the two interrupt pins
`timescale 1ns/1ns

module epr_ext_logic (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic raiseIrq,
	input wire logic raiseNmi,
	input wire logic ackIrq,
	input wire logic ackNmi,
	output logic irqPinN,
	output logic nmiPinN
);
	logic irqHeld_r;
	logic nmiHeld_r;

	// Held low until the handler acknowledges, so no service finds an empty source
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			irqHeld_r <= 1'h0;
			nmiHeld_r <= 1'h0;
		end
		else
		begin
			irqHeld_r <= raiseIrq | (irqHeld_r & !ackIrq);
			nmiHeld_r <= raiseNmi | (nmiHeld_r & !ackNmi);
		end
	end

	// Pull-ups take released pins back high
	assign irqPinN = !irqHeld_r;
	assign nmiPinN = !nmiHeld_r;
endmodule

// ### exception_priority_resolver_tb.sv
// Scenario bench for the exception priority resolver
`timescale 1ns/1ns
`include "epr_regs.svh"

module exception_priority_resolver_tb;
	logic sys_clk, nrst, iMaskWr, iMaskWrData, xMaskWr, xMaskWrData, prioWr, edgeSelWr;
	logic edgeSelWrData, specialMode, serviceStart, raiseIrq, raiseNmi, ackIrq, ackNmi;
	logic [4:0] nmReq;
	logic [7:0] prioWrData, prio_r;
	logic [`EPR_NSRC-1:1] flagSet, flagClr, flags_r;
	epr_pkg::epr_src_t localEn;
	epr_pkg::epr_grant_e grant_r;
	logic nmiPinN, irqPinN, iMask_r, xMask_r, edgeSel_r, vectorValid_r, pendingAny_r;
	logic [15:0] vectorAddr_r;
	int mismatches, checks;

	epr_ext_logic ext (.sys_clk(sys_clk), .nrst(nrst), .raiseIrq(raiseIrq), .raiseNmi(raiseNmi),
		.ackIrq(ackIrq), .ackNmi(ackNmi), .irqPinN(irqPinN), .nmiPinN(nmiPinN));

	epr_resolver DUT (.sys_clk(sys_clk), .nrst(nrst), .resetPinReq(nmReq[0]),
		.clkMonReq(nmReq[1]), .watchdogReq(nmReq[2]), .illegalOpReq(nmReq[3]),
		.swiReq(nmReq[4]), .nmiPinN(nmiPinN), .irqPinN(irqPinN), .flagSet(flagSet),
		.flagClr(flagClr), .localEn(localEn), .iMaskWr(iMaskWr), .iMaskWrData(iMaskWrData),
		.xMaskWr(xMaskWr), .xMaskWrData(xMaskWrData), .prioWr(prioWr), .prioWrData(prioWrData),
		.edgeSelWr(edgeSelWr), .edgeSelWrData(edgeSelWrData), .specialMode(specialMode),
		.serviceStart(serviceStart), .iMask_r(iMask_r), .xMask_r(xMask_r), .prio_r(prio_r),
		.edgeSel_r(edgeSel_r), .flags_r(flags_r), .pendingAny_r(pendingAny_r),
		.vectorValid_r(vectorValid_r), .vectorAddr_r(vectorAddr_r), .grant_r(grant_r));

	initial
	begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// Far-side pulse: 0 raise irq, 1 ack irq, 2 raise nmi, 3 ack nmi
	task automatic poke(input int sel);
		tick(1);
		{raiseIrq, ackIrq, raiseNmi, ackNmi} = {sel == 0, sel == 1, sel == 2, sel == 3};
		tick(1);
		{raiseIrq, ackIrq, raiseNmi, ackNmi} = 4'h0;
	endtask

	task automatic doReset;
		nrst = 1'h0;
		tick(10);
		nrst = 1'h1;
	endtask

	// One strobe at a time: 0 global mask, 1 pin mask, 2 elevation, 3 edge select
	task automatic wr(input int sel, input logic [7:0] v);
		tick(1);
		{iMaskWrData, xMaskWrData, edgeSelWrData, prioWrData} = {v[0], v[0], v[0], v};
		iMaskWr = (sel == 0);
		xMaskWr = (sel == 1);
		prioWr = (sel == 2);
		edgeSelWr = (sel == 3);
		tick(1);
		{iMaskWr, xMaskWr, prioWr, edgeSelWr} = 4'h0;
	endtask

	// Vector is due exactly one cycle after the service pulse
	task automatic serve(input logic [15:0] ea, input epr_pkg::epr_grant_e eg);
		tick(1);
		chk("pending", 16'(eg != epr_pkg::GR_TRAP), pendingAny_r);
		chk("valid idle", 16'h0, vectorValid_r);
		serviceStart = 1'h1;
		tick(1);
		serviceStart = 1'h0;
		chk("valid", 16'h1, vectorValid_r);
		chk("vector", ea, vectorAddr_r);
		chk("grant", eg, grant_r);
	endtask

	task automatic tReset;
		chk("iMask", 16'h1, iMask_r);
		chk("xMask", 16'h1, xMask_r);
		chk("prio", 16'hf2, prio_r);
		chk("edgeSel", 16'h0, edgeSel_r);
		chk("vector", 16'hfffe, vectorAddr_r);
		chk("pending", 16'h0, pendingAny_r);
	endtask

	task automatic tNonMask;
		logic [15:0] va[6];
		epr_pkg::epr_grant_e ga[6];
		va = '{16'hfffe, 16'hfffc, 16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4};
		ga = '{epr_pkg::GR_RESET, epr_pkg::GR_CLKMON, epr_pkg::GR_WATCHDOG,
			epr_pkg::GR_ILLEGAL, epr_pkg::GR_SWI, epr_pkg::GR_NMI};
		poke(2);
		serve(16'hfff8, epr_pkg::GR_TRAP);
		wr(1, 8'h0);
		nmReq = 5'h1f;
		for (int i = 0; i < 6; i++)
		begin
			serve(va[i], ga[i]);
			if (i < 5)
				nmReq[i] = 1'h0;
		end
		poke(3);
		serve(16'hfff8, epr_pkg::GR_TRAP);
	endtask

	task automatic tMaskable;
		tick(1);
		flagSet[2] = 1'h1;
		flagSet[5] = 1'h1;
		tick(1);
		flagSet = '0;
		serve(16'hfff8, epr_pkg::GR_TRAP);
		chk("flags", 16'h9, flags_r[5:2]);
		wr(0, 8'h0);
		wr(2, 8'he8);
		chk("prio", 16'hf2, prio_r);
		serve(16'hffee, epr_pkg::GR_MASKABLE);
		wr(0, 8'h1);
		wr(2, 8'he8);
		chk("prio", 16'he8, prio_r);
		wr(0, 8'h0);
		serve(16'hffe8, epr_pkg::GR_MASKABLE);
		localEn[5] = 1'h0;
		serve(16'hffee, epr_pkg::GR_MASKABLE);
		localEn[5] = 1'h1;
		wr(0, 8'h1);
		wr(2, 8'he9);
		wr(0, 8'h0);
		serve(16'hffee, epr_pkg::GR_MASKABLE);
		wr(0, 8'h1);
		flagClr[2] = 1'h1;
		flagClr[5] = 1'h1;
		tick(1);
		flagClr = '0;
		localEn[5] = 1'h1;
		tick(1);
		flagSet[3] = 1'h1;
		flagClr[3] = 1'h1;
		tick(1);
		{flagSet, flagClr} = '0;
		chk("flag set wins", 16'h1, flags_r[3]);
		flagClr[3] = 1'h1;
		tick(1);
		flagClr = '0;
		chk("flag cleared", 16'h0, flags_r[3]);
		wr(0, 8'h0);
		serve(16'hfff8, epr_pkg::GR_TRAP);
	endtask

	task automatic tLevel;
		poke(0);
		tick(2);
		serve(16'hfff2, epr_pkg::GR_MASKABLE);
		serve(16'hfff2, epr_pkg::GR_MASKABLE);
		poke(1);
		tick(2);
		serve(16'hfff8, epr_pkg::GR_TRAP);
	endtask

	task automatic tEdge;
		wr(3, 8'h1);
		wr(3, 8'h0);
		chk("edgeSel", 16'h1, edgeSel_r);
		poke(0);
		poke(1);
		tick(3);
		serve(16'hfff2, epr_pkg::GR_MASKABLE);
		serve(16'hfff8, epr_pkg::GR_TRAP);
	endtask

	task automatic tSpecial;
		specialMode = 1'h1;
		doReset();
		tReset();
		wr(3, 8'h1);
		chk("edgeSel", 16'h0, edgeSel_r);
		wr(3, 8'h1);
		chk("edgeSel", 16'h1, edgeSel_r);
	endtask

	initial
	begin
		{nrst, iMaskWr, iMaskWrData, xMaskWr, xMaskWrData, prioWr, edgeSelWr} = '0;
		{edgeSelWrData, specialMode, serviceStart, raiseIrq, raiseNmi, ackIrq, ackNmi} = '0;
		nmReq = '0;
		prioWrData = '0;
		flagSet = '0;
		flagClr = '0;
		localEn = '1;
		mismatches = 0;
		checks = 0;
		doReset();
		tReset();
		tNonMask();
		tMaskable();
		tLevel();
		tEdge();
		tSpecial();
		conclude();
	end

	// Hang guard
	initial
	begin
		#40000;
		mismatches++;
		conclude();
	end
endmodule
